// >>> logic/gpo_defs.svh
// Constants for the general-purpose port pin block
`ifndef GPO_DEFS_SVH
`define GPO_DEFS_SVH
`define GPO_ADDR_DIR      4'h0
`define GPO_ADDR_LATCH    4'h1
`define GPO_ADDR_SAMPLE   4'h2
`define GPO_ADDR_CTRL     4'h3
`define GPO_ADDR_EVT      4'h4
`define GPO_ADDR_IRQEN    4'h5
`define GPO_CTRL_PUD_BIT  0
`define GPO_CTRL_SLEEP_BIT 1
`define GPO_DIR_RST       8'h00
`define GPO_LATCH_RST     8'h00
`define GPO_CTRL_RST      8'h00
`define GPO_IRQEN_RST     8'h00
`define GPO_CLK_PERIOD_NS 50
`define GPO_SYNC_DLY_NS   50
`define GPO_SYNC_DLY_CYC  ((`GPO_SYNC_DLY_NS + `GPO_CLK_PERIOD_NS - 1) / `GPO_CLK_PERIOD_NS)
`endif

// >>> logic/gpo_pin_ctrl.sv
// Per-pin pad control with alternate-function overrides
`timescale 1ns/10ps
module gpo_pin_ctrl (
    // Pin register bits
    input  wire logic          srst,
    input  wire logic          pin_direction_bit,
    input  wire logic          pin_output_latch_bit,
    input  wire logic          global_pullup_disable,
    // Overrides
    input  wire gpo_pkg::gpo_ovr_s ovr,
    // Pad control
    output gpo_pkg::gpo_pad_s  pad
);
    import gpo_pkg::*;

    always_comb begin
        pad = '0;
        if (ovr.dir_oe) begin
            pad.drive_en = ovr.dir_ov;
        end else begin
            pad.drive_en = pin_direction_bit;
        end
        pad.drive_val = ovr.val_oe ? ovr.val_ov : pin_output_latch_bit;
        if (ovr.pu_oe) begin
            pad.pullup_en = ovr.pu_ov;
        end else begin
            pad.pullup_en = ({pin_direction_bit, pin_output_latch_bit, global_pullup_disable} == 3'b010);
        end
        if (srst) begin
            pad.drive_en  = 1'b0;
            pad.pullup_en = 1'b0;
        end
    end
endmodule : gpo_pin_ctrl

// >>> logic/gpo_pkg.sv
// Types shared by the port pin block
package gpo_pkg;
    typedef struct packed {
        logic pu_oe;
        logic pu_ov;
        logic dir_oe;
        logic dir_ov;
        logic val_oe;
        logic val_ov;
        logic ie_oe;
        logic ie_ov;
    } gpo_ovr_s;

    typedef struct packed {
        logic drive_en;
        logic drive_val;
        logic pullup_en;
    } gpo_pad_s;

    typedef enum logic [1:0] {
        GPO_RUN,
        GPO_CLAMP,
        GPO_WAKE
    } gpo_sleep_e;
endpackage : gpo_pkg

// >>> logic/gpo_port.sv
// General-purpose port: pin registers, input sync, sleep clamp and overrides
`timescale 1ns/10ps
`include "gpo_defs.svh"
module gpo_port #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    // Register port
    input  wire logic [3:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata_ff,
    // Sleep controller
    input  wire logic                     deep_sleep_req,
    // Alternate-function overrides, one set per pin
    input  wire gpo_pkg::gpo_ovr_s [WIDTH-1:0] ovr,
    // Pad side
    input  wire logic [WIDTH-1:0]         pad_in,
    output logic      [WIDTH-1:0]         pad_out_ff,
    output logic      [WIDTH-1:0]         pad_oe_ff,
    output logic      [WIDTH-1:0]         pad_pullup_ff,
    // Alternate-function inputs
    output logic      [WIDTH-1:0]         alt_function_raw_input_ff,
    output logic      [WIDTH-1:0]         input_gate_ff,
    output logic                          sleep_clamp_ff
);
    import gpo_pkg::*;

    logic [WIDTH-1:0] pin_direction_bit_ff;
    logic [WIDTH-1:0] pin_output_latch_bit_ff;
    logic [WIDTH-1:0] pin_state_sample_bit;
    logic [WIDTH-1:0] irq_enable_ff;
    logic [WIDTH-1:0] event_ff;
    logic [WIDTH-1:0] prev_sample_ff;
    logic             global_pullup_disable_ff;
    gpo_sleep_e       sleep_state_ff;
    gpo_sleep_e       nxt_sleep_state;
    logic [WIDTH-1:0] input_gate;
    logic [WIDTH-1:0] schmitt_out;
    gpo_pad_s         pad_ctl [WIDTH];
    logic [WIDTH-1:0] nxt_pad_out;
    logic [WIDTH-1:0] nxt_pad_oe;
    logic [WIDTH-1:0] nxt_pad_pu;

    function automatic logic [7:0] zext(input logic [WIDTH-1:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < WIDTH && i < 8; i++) begin
            r[i] = v[i];
        end
        return r;
    endfunction : zext

    // Register writes, one shared strobe for all pins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_direction_bit_ff    <= WIDTH'(`GPO_DIR_RST);
            pin_output_latch_bit_ff <= WIDTH'(`GPO_LATCH_RST);
            irq_enable_ff           <= WIDTH'(`GPO_IRQEN_RST);
            global_pullup_disable_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `GPO_ADDR_DIR) begin
                pin_direction_bit_ff <= reg_wdata[WIDTH-1:0];
            end else if (reg_addr == `GPO_ADDR_LATCH) begin
                pin_output_latch_bit_ff <= reg_wdata[WIDTH-1:0];
            end else if (reg_addr == `GPO_ADDR_CTRL) begin
                global_pullup_disable_ff <= reg_wdata[`GPO_CTRL_PUD_BIT];
            end else if (reg_addr == `GPO_ADDR_IRQEN) begin
                irq_enable_ff <= reg_wdata[WIDTH-1:0];
            end
        end
    end

    // Sleep state: clamp during deep sleep, one wake cycle on release
    always_comb begin
        nxt_sleep_state = sleep_state_ff;
        case (sleep_state_ff)
            GPO_RUN: begin
                if (deep_sleep_req) begin
                    nxt_sleep_state = GPO_CLAMP;
                end
            end
            GPO_CLAMP: begin
                if (!deep_sleep_req) begin
                    nxt_sleep_state = GPO_WAKE;
                end
            end
            default: begin
                nxt_sleep_state = deep_sleep_req ? GPO_CLAMP : GPO_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sleep_state_ff <= GPO_RUN;
            sleep_clamp_ff <= 1'b0;
        end else begin
            sleep_state_ff <= nxt_sleep_state;
            sleep_clamp_ff <= (nxt_sleep_state == GPO_CLAMP);
        end
    end

    // Input enable and clamp to ground at the Schmitt input
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (ovr[i].ie_oe) begin
                input_gate[i] = ovr[i].ie_ov;
            end else if (irq_enable_ff[i]) begin
                input_gate[i] = 1'b1;
            end else begin
                input_gate[i] = (sleep_state_ff != GPO_CLAMP);
            end
            schmitt_out[i] = pad_in[i] & input_gate[i];
        end
    end

    // Per-pin synchronizers and pad control
    for (genvar g = 0; g < WIDTH; g++) begin : g_pin
        gpo_sync u_sync (
            .ref_clk (ref_clk),
            .srst    (srst),
            .din     (schmitt_out[g]),
            .dout_ff (pin_state_sample_bit[g])
        );

        gpo_pin_ctrl u_ctrl (
            .srst                  (srst),
            .pin_direction_bit     (pin_direction_bit_ff[g]),
            .pin_output_latch_bit  (pin_output_latch_bit_ff[g]),
            .global_pullup_disable (global_pullup_disable_ff),
            .ovr                   (ovr[g]),
            .pad                   (pad_ctl[g])
        );
    end

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            nxt_pad_oe[i]  = pad_ctl[i].drive_en;
            nxt_pad_out[i] = pad_ctl[i].drive_val & pad_ctl[i].drive_en;
            nxt_pad_pu[i]  = pad_ctl[i].pullup_en;
        end
    end

    // Pad outputs; reset forces float on the next clock edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pad_oe_ff     <= '0;
            pad_out_ff    <= '0;
            pad_pullup_ff <= '0;
        end else begin
            pad_oe_ff     <= nxt_pad_oe;
            pad_out_ff    <= nxt_pad_out;
            pad_pullup_ff <= nxt_pad_pu;
        end
    end

    // Raw input for alternate functions, no synchronizer applied
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            alt_function_raw_input_ff <= '0;
            input_gate_ff             <= '0;
        end else begin
            alt_function_raw_input_ff <= schmitt_out;
            input_gate_ff             <= input_gate;
        end
    end

    // Change events on the synchronized level; set wins over clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_sample_ff <= '0;
            event_ff       <= '0;
        end else begin
            prev_sample_ff <= pin_state_sample_bit;
            if (reg_wr && reg_addr == `GPO_ADDR_EVT) begin
                event_ff <= (event_ff & ~reg_wdata[WIDTH-1:0]) | (pin_state_sample_bit ^ prev_sample_ff);
            end else begin
                event_ff <= event_ff | (pin_state_sample_bit ^ prev_sample_ff);
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd) begin
            if (reg_addr == `GPO_ADDR_DIR) begin
                reg_rdata_ff <= zext(pin_direction_bit_ff);
            end else if (reg_addr == `GPO_ADDR_LATCH) begin
                reg_rdata_ff <= zext(pin_output_latch_bit_ff);
            end else if (reg_addr == `GPO_ADDR_SAMPLE) begin
                reg_rdata_ff <= zext(pin_state_sample_bit);
            end else if (reg_addr == `GPO_ADDR_CTRL) begin
                reg_rdata_ff <= {6'h00, sleep_clamp_ff, global_pullup_disable_ff};
            end else if (reg_addr == `GPO_ADDR_EVT) begin
                reg_rdata_ff <= zext(event_ff);
            end else if (reg_addr == `GPO_ADDR_IRQEN) begin
                reg_rdata_ff <= zext(irq_enable_ff);
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end

    // Analog path is a pad-level connection outside this digital block
endmodule : gpo_port

// >>> logic/gpo_sync.sv
// Latch-plus-flop input synchronizer for one pin
`timescale 1ns/10ps
module gpo_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // Data
    input  wire logic din,
    output logic      dout_ff
);
    logic sync_latch;

    // Transparent while the clock is high, holds while low
    always_latch begin
        if (ref_clk) begin
            sync_latch <= din;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dout_ff <= 1'b0;
        end else begin
            dout_ff <= sync_latch;
        end
    end
endmodule : gpo_sync

// >>> verification/gpo_pad_model.sv
// Pad and outside world for the port pins
`timescale 1ns/10ps
module gpo_pad_model #(
    parameter int WIDTH = 8
) (
    // Clock
    input  wire logic             ref_clk,
    // Pad control from the port
    input  wire logic [WIDTH-1:0] pad_oe_ff,
    input  wire logic [WIDTH-1:0] pad_out_ff,
    input  wire logic [WIDTH-1:0] pad_pullup_ff,
    // Outside driver
    input  wire logic [WIDTH-1:0] ext_en,
    input  wire logic [WIDTH-1:0] ext_val,
    // Resolved pin level
    output logic      [WIDTH-1:0] pad_in
);
    logic [WIDTH-1:0] last_ff = '0;
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pad_oe_ff[i]) pad_in[i] = pad_out_ff[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pullup_ff[i]) pad_in[i] = 1'b1;
            else pad_in[i] = ~last_ff[i];
        end
    end
    // Floating pin wanders every cycle
    always_ff @(posedge ref_clk) last_ff <= pad_in;
endmodule : gpo_pad_model

// >>> verification/gpo_port_props.sv
// Concurrent checks on the port pin block ports
`timescale 1ns/10ps
`include "gpo_defs.svh"
module gpo_port_props #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic                          ref_clk,
    input wire logic                          srst,
    // Register port
    input wire logic [3:0]                    reg_addr,
    input wire logic [7:0]                    reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [7:0]                    reg_rdata_ff,
    // Sleep and overrides
    input wire logic                          deep_sleep_req,
    input wire gpo_pkg::gpo_ovr_s [WIDTH-1:0] ovr,
    // Pad side
    input wire logic [WIDTH-1:0]              pad_in,
    input wire logic [WIDTH-1:0]              pad_out_ff,
    input wire logic [WIDTH-1:0]              pad_oe_ff,
    input wire logic [WIDTH-1:0]              pad_pullup_ff,
    // Alternate-function side
    input wire logic [WIDTH-1:0]              alt_function_raw_input_ff,
    input wire logic [WIDTH-1:0]              input_gate_ff,
    input wire logic                          sleep_clamp_ff
);
    import gpo_pkg::*;
    logic [WIDTH-1:0] dir_sh_ff, lat_sh_ff, irq_sh_ff, e_oe, e_out, e_pu, e_gate;
    logic             pud_sh_ff;
    default clocking cb @(posedge ref_clk); endclocking
    // Shadow of the direction, latch and IRQ-enable registers and the pull-up disable bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {dir_sh_ff, lat_sh_ff, irq_sh_ff, pud_sh_ff} <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `GPO_ADDR_DIR) dir_sh_ff <= reg_wdata[WIDTH-1:0];
            if (reg_addr == `GPO_ADDR_LATCH) lat_sh_ff <= reg_wdata[WIDTH-1:0];
            if (reg_addr == `GPO_ADDR_IRQEN) irq_sh_ff <= reg_wdata[WIDTH-1:0];
            if (reg_addr == `GPO_ADDR_CTRL) pud_sh_ff <= reg_wdata[`GPO_CTRL_PUD_BIT];
        end
    end
    // Expected pad control and input gate per pin
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            e_oe[i]   = ovr[i].dir_oe ? ovr[i].dir_ov : dir_sh_ff[i];
            e_out[i]  = e_oe[i] & (ovr[i].val_oe ? ovr[i].val_ov : lat_sh_ff[i]);
            e_pu[i]   = ovr[i].pu_oe ? ovr[i].pu_ov : ~dir_sh_ff[i] & lat_sh_ff[i] & ~pud_sh_ff;
            e_gate[i] = ovr[i].ie_oe ? ovr[i].ie_ov : ~sleep_clamp_ff | irq_sh_ff[i];
        end
    end
    sequence s_pad_steady;
        $stable(pad_in) && (&input_gate_ff) ##1 $stable(pad_in) && (&input_gate_ff);
    endsequence
    a_reset_float: assert property (srst |=> pad_oe_ff == '0 && pad_pullup_ff == '0)
        else $error("pad not floating after reset");
    a_drive_enable: assert property (disable iff (srst) !$past(srst) |-> pad_oe_ff == $past(e_oe))
        else $error("driver enable wrong");
    a_drive_level: assert property (disable iff (srst) !$past(srst) |-> pad_out_ff == $past(e_out))
        else $error("driven level wrong");
    a_pullup_select: assert property (disable iff (srst) !$past(srst) |-> pad_pullup_ff == $past(e_pu))
        else $error("pull-up wrong");
    a_clamp_follow: assert property (disable iff (srst) !$past(srst) |-> sleep_clamp_ff == $past(deep_sleep_req))
        else $error("clamp wrong");
    a_sleep_gate: assert property (disable iff (srst) !$past(srst) |-> input_gate_ff == $past(e_gate))
        else $error("input gate wrong");
    a_sample_read: assert property (disable iff (srst)
        s_pad_steady ##0 (reg_rd && reg_addr == `GPO_ADDR_SAMPLE) |=> reg_rdata_ff[WIDTH-1:0] == $past(pad_in))
        else $error("sample read wrong");
    a_raw_input: assert property (disable iff (srst)
        (&input_gate_ff) && $past(&input_gate_ff) |-> alt_function_raw_input_ff == $past(pad_in))
        else $error("raw input wrong");
endmodule : gpo_port_props
bind gpo_port gpo_port_props #(.WIDTH(WIDTH)) i_props (.*);

// >>> verification/gpo_port_tb.sv
// Self-checking testbench for the port pin block
`timescale 1ns/10ps
`include "gpo_defs.svh"
module gpo_port_tb;
    import gpo_pkg::*;
    localparam int WIDTH = 8;
    localparam logic [10:0] OVT [6] = '{11'h000, 11'h601, 11'h184, 11'h1e6, 11'h060, 11'h018};
    localparam logic [3:0] RA [5] = '{`GPO_ADDR_DIR, `GPO_ADDR_LATCH, `GPO_ADDR_CTRL, `GPO_ADDR_IRQEN, 4'hf};
    logic                 ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, deep_sleep_req = 1'b0;
    logic [3:0]           reg_addr = 4'h0;
    logic [7:0]           reg_wdata = 8'h00, reg_rdata_ff;
    gpo_ovr_s [WIDTH-1:0] ovr = '0;
    logic [WIDTH-1:0]     ext_en = '0, ext_val = '0, pad_in, pad_out_ff, pad_oe_ff, pad_pullup_ff;
    logic [WIDTH-1:0]     alt_function_raw_input_ff, input_gate_ff;
    logic                 sleep_clamp_ff;
    int                   error_cnt = 0, n_tests = 0;

    gpo_port #(.WIDTH(WIDTH)) i_dut (.*);
    gpo_pad_model #(.WIDTH(WIDTH)) i_pad (.*);

    always #25 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata_ff, exp);
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        #1 chk("pads in reset", pad_oe_ff | pad_out_ff | pad_pullup_ff, 8'h00);
        foreach (RA[i]) rdc("reset value", RA[i], 8'h00);
        // Outputs on the low nibble, pull-ups and outside drive above
        wr(`GPO_ADDR_DIR, 8'h0f);
        wr(`GPO_ADDR_LATCH, 8'ha5);
        @(posedge ref_clk);
        ext_en <= 8'h50;
        ext_val <= 8'h50;
        wr(`GPO_ADDR_SAMPLE, 8'h00);
        idle(2);
        chk("drive enable", pad_oe_ff, 8'h0f);
        chk("drive level", pad_out_ff, 8'h05);
        chk("pull-up", pad_pullup_ff, 8'ha0);
        rdc("sample", `GPO_ADDR_SAMPLE, 8'hf5);
        @(posedge ref_clk);
        ext_val <= 8'h40;
        rdc("outside edge", `GPO_ADDR_SAMPLE, 8'he5);
        wr(`GPO_ADDR_LATCH, 8'ha4);
        rdc("readback no gap", `GPO_ADDR_SAMPLE, 8'he5);
        rdc("readback gap", `GPO_ADDR_SAMPLE, 8'he4);
        wr(`GPO_ADDR_CTRL, 8'h01);
        idle(1);
        chk("pull-up disabled", pad_pullup_ff, 8'h00);
        wr(`GPO_ADDR_CTRL, 8'h00);
        // Override combinations on pin 4
        foreach (OVT[k]) begin
            @(posedge ref_clk);
            ovr[4] <= OVT[k][10:3];
            idle(1);
            chk("override", {5'h00, pad_oe_ff[4], pad_out_ff[4], pad_pullup_ff[4]}, {5'h00, OVT[k][2:0]});
        end
        wr(`GPO_ADDR_IRQEN, 8'h10);
        @(posedge ref_clk);
        ovr[4] <= '0;
        ovr[6] <= 8'h03;
        idle(3);
        wr(`GPO_ADDR_EVT, 8'hff);
        @(posedge ref_clk);
        deep_sleep_req <= 1'b1;
        idle(3);
        chk("gate asleep", input_gate_ff, 8'h50);
        chk("raw input asleep", alt_function_raw_input_ff, 8'h40);
        rdc("clamp flag", `GPO_ADDR_CTRL, 8'h02);
        rdc("sample asleep", `GPO_ADDR_SAMPLE, 8'h40);
        @(posedge ref_clk);
        deep_sleep_req <= 1'b0;
        idle(4);
        chk("gate awake", input_gate_ff, 8'hff);
        rdc("wake events", `GPO_ADDR_EVT, 8'ha4);
        summarize();
    end
endmodule : gpo_port_tb
